// >>> hw/gfm_mux.sv
// general pin function multiplexer: per-pin mode registers, indicator patterns, pin drive
// assumes avalon-mm master on ref_clk; pin inputs asynchronous, two-flop synchronised
// What this block does
// - fourteen pins each pick input, output or special function by mode code.
// - mode 9 burst indicator only on pin one; none by default.
// - burst pin rises with the window input, which must lead the first slot by 10 us; falls 5 us after last.
// - supply enable defaults to pin two; pins 1-5 allowed; one pin only.
// - supply enable pin follows positioning control setting, low by default.
// - mode 4 only on pin three; wakes when control 1 and io setting 16.
// - data ready pin otherwise tri-stated with pull-down; default.
// - mode 5 only on pin four; sync out when control 1, io 32.
// - mode 7 only on pin five, its default; input with pull-down.
// - card detect low means absent, high present; this block pulls the pin down.
// - each card detect level change raises a status change event.
// - mode 2 network status on pins 1-5, one pin, none by default.
// - network status low with no service.
// - home 2G: 100 ms high, 2 s low, repeated.
// - home 3G: 50 high, 50 low, 50 high, 2 s low.
// - roaming 2G: 100 high, 100 low, 100 high, 2 s low.
// - roaming 3G: 50 high, 50 low, 50 high, 100 low.
// - network status high during a call.
// - mode 10 on pin one or thirteen, one pin; high when on.
// - mode 11 on pin fourteen or five, one pin; high when active.
// - pins six to nine default to mode 12; no other pin accepts it.
//
// Implementation choices: register access over Avalon-MM and the address map.
module gfm_mux
  import gfm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  output logic [NUM_PINS-1:0] pin_pulldown,
  input wire logic tx_burst_window,
  input wire logic module_on,
  input wire logic module_active,
  input wire logic time_sync_in,
  input wire logic audio2_tx,
  input wire logic audio2_bitclk_out,
  input wire logic audio2_word_align_out,
  input wire logic audio2_master,
  output logic audio2_rx,
  output logic audio2_bitclk_in,
  output logic audio2_word_align_in,
  output logic wake_request,
  output logic card_present,
  output logic card_event
);
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_ACK = 4'b0010,
    BUS_XX1 = 4'b0100,
    BUS_XX2 = 4'b1000
  } gfm_bus_type;

  gfm_mode_type mode_r [NUM_PINS];
  logic pos_ctrl_r;
  logic [7:0] pos_io_r;
  logic [2:0] net_state_r;
  logic [NUM_PINS-1:0] gp_out_r;
  logic [NUM_PINS-1:0] sync1_r, sync2_r;
  logic card_prev_r;
  logic card_event_r;
  logic [7:0] error_r;
  gfm_bus_type bus_r;
  logic [31:0] rdata_r;
  logic burst_out_r;
  logic [10:0] burst_cnt_r;
  logic [16:0] tick_cnt_r;
  logic tick;
  logic [11:0] ms_cnt_r;
  logic [1:0] phase_r;
  logic net_out;

  // permitted codes per pin (pin index 0-based)
  function automatic logic mode_allowed(input int pin, input gfm_mode_type m);
    case (m)
      MODE_OUTPUT, MODE_INPUT, MODE_PAD_OFF: mode_allowed = 1'b1;
      MODE_TX_BURST: mode_allowed = (pin == 0);
      MODE_POS_SUPPLY, MODE_NETSTAT: mode_allowed = (pin <= 4);
      MODE_DATA_READY: mode_allowed = (pin == 2);
      MODE_TIME_SYNC: mode_allowed = (pin == 3);
      MODE_CARD_DET: mode_allowed = (pin == 4);
      MODE_POWER_IND: mode_allowed = (pin == 0) || (pin == 12);
      MODE_OPMODE_IND: mode_allowed = (pin == 13) || (pin == 4);
      MODE_AUDIO2: mode_allowed = (pin >= 5) && (pin <= 8);
      MODE_SERIAL: mode_allowed = (pin >= 9); // serial mode accepted only on pins ten to fourteen, their default
      default: mode_allowed = 1'b0;
    endcase
  endfunction

  function automatic logic single_pin(input gfm_mode_type m);
    single_pin = (m == MODE_POS_SUPPLY) || (m == MODE_NETSTAT) || (m == MODE_TX_BURST)
      || (m == MODE_POWER_IND) || (m == MODE_OPMODE_IND);
  endfunction

  function automatic gfm_mode_type mode_default(input int pin);
    if (pin == 1)
      mode_default = MODE_POS_SUPPLY;
    else if (pin == 2)
      mode_default = MODE_DATA_READY;
    else if (pin == 3)
      mode_default = MODE_TIME_SYNC;
    else if (pin == 4)
      mode_default = MODE_CARD_DET;
    else if (pin >= 5 && pin <= 8)
      mode_default = MODE_AUDIO2;
    else if (pin >= 9)
      mode_default = MODE_SERIAL;
    else
      mode_default = MODE_PAD_OFF;
  endfunction

  // bus decode
  logic wr_go, rd_go;
  logic [3:0] wr_pin;
  logic wr_mode;
  logic taken;
  // writes land only at the edge that accepts them, waitrequest low
  assign wr_go = avs_write && (bus_r == BUS_ACK);
  assign rd_go = avs_read && (bus_r == BUS_IDLE);
  assign wr_pin = avs_address[5:2];
  assign wr_mode = (avs_address[7:6] == 2'b00) && (wr_pin < 4'(NUM_PINS));
  always_comb
  begin
    taken = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (i != int'(wr_pin) && mode_r[i] == avs_writedata[7:0])
        taken = 1'b1;
    end
  end

  // one wait cycle, answered on the next
  assign avs_waitrequest = (avs_read || avs_write) && (bus_r == BUS_IDLE);
  assign avs_readdata = rdata_r;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      bus_r <= BUS_IDLE;
    else if (bus_r == BUS_IDLE && (avs_read || avs_write))
      bus_r <= BUS_ACK;
    else
      bus_r <= BUS_IDLE;
  end

  // mode registers; a rejected code leaves the old mode and flags the error register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        mode_r[i] <= mode_default(i);
      error_r <= 8'h00;
    end
    else if (wr_go && wr_mode && avs_byteenable[0])
    begin
      if (mode_allowed(int'(wr_pin), avs_writedata[7:0])
          && !(single_pin(avs_writedata[7:0]) && taken))
      begin
        mode_r[wr_pin] <= avs_writedata[7:0];
        error_r <= 8'h00;
      end
      else
        error_r <= {4'h1, wr_pin};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pos_ctrl_r <= 1'b0;
      pos_io_r <= 8'h00;
      net_state_r <= NET_NONE;
      gp_out_r <= '0;
    end
    else if (wr_go && avs_byteenable[0])
    begin
      if (avs_address == OFS_POS_CTRL)
        pos_ctrl_r <= avs_writedata[0];
      if (avs_address == OFS_POS_IO)
        pos_io_r <= avs_writedata[7:0];
      if (avs_address == OFS_NET_STATE)
        net_state_r <= avs_writedata[2:0];
      if (avs_address == OFS_GP_OUT)
        gp_out_r[7:0] <= avs_writedata[7:0];
      if (avs_address == OFS_GP_OUT && avs_byteenable[1])
        gp_out_r[13:8] <= avs_writedata[13:8];
    end
    else if (wr_go && avs_byteenable[1] && avs_address == OFS_GP_OUT)
      gp_out_r[13:8] <= avs_writedata[13:8];
  end

  // read data
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rdata_r <= RD_UNMAPPED;
    else if (rd_go)
    begin
      if (wr_mode)
        rdata_r <= {24'h0, mode_r[wr_pin]};
      else if (avs_address == OFS_POS_CTRL)
        rdata_r <= {31'h0, pos_ctrl_r};
      else if (avs_address == OFS_POS_IO)
        rdata_r <= {24'h0, pos_io_r};
      else if (avs_address == OFS_NET_STATE)
        rdata_r <= {29'h0, net_state_r};
      else if (avs_address == OFS_GP_OUT)
        rdata_r <= {18'h0, gp_out_r};
      else if (avs_address == OFS_STATUS)
        rdata_r <= {29'h0, wake_request, card_event_r, card_present};
      else if (avs_address == OFS_GP_IN)
        rdata_r <= {18'h0, sync2_r};
      else if (avs_address == OFS_ERROR)
        rdata_r <= {24'h0, error_r};
      else
        rdata_r <= RD_UNMAPPED;
    end
  end

  // pin synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  assign card_present = sync2_r[4] && (mode_r[4] == MODE_CARD_DET);

  // card change event; a new change beats a status-register write-1 clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      card_prev_r <= 1'b0;
      card_event_r <= 1'b0;
    end
    else
    begin
      card_prev_r <= sync2_r[4];
      if (mode_r[4] == MODE_CARD_DET && sync2_r[4] != card_prev_r)
        card_event_r <= 1'b1;
      else if (wr_go && avs_address == OFS_STATUS && avs_byteenable[0]
               && avs_writedata[ST_CARD_EVENT])
        card_event_r <= 1'b0;
    end
  end
  assign card_event = card_event_r;

  assign wake_request = (mode_r[2] == MODE_DATA_READY) && pos_ctrl_r
    && (pos_io_r == POS_IO_WAKE) && sync2_r[2];

  // burst indicator: the window input is expected to lead the slots by the lead time
  // already, so only the tail stretch is made here; lead is a contract on the source
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      burst_out_r <= 1'b0;
      burst_cnt_r <= '0;
    end
    else if (tx_burst_window)
    begin
      burst_out_r <= 1'b1;
      burst_cnt_r <= 11'(BURST_TAIL_CYC);
    end
    else if (burst_cnt_r != '0)
      burst_cnt_r <= burst_cnt_r - 11'd1;
    else
      burst_out_r <= 1'b0;
  end

  // millisecond tick
  assign tick = (tick_cnt_r == 17'(TICK_CYC - 1));
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 17'd1;
  end

  // blink: phases high, low, high, long low; durations in ms per state
  logic [11:0] ph_len;
  logic single_blink;
  always_comb
  begin
    single_blink = (net_state_r == NET_HOME_2G);
    case (phase_r)
      2'd3: ph_len = (net_state_r == NET_ROAM_3G) ? 12'(T100_MS) : 12'(T2S_MS);
      default: ph_len = (net_state_r == NET_HOME_3G || net_state_r == NET_ROAM_3G)
        ? 12'(T50_MS) : 12'(T100_MS);
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    // restart from the high phase whenever software sets a new state
    if (!resetn || net_state_r == NET_NONE || net_state_r == NET_CALL
        || (wr_go && avs_address == OFS_NET_STATE))
    begin
      ms_cnt_r <= '0;
      phase_r <= 2'd0;
    end
    else if (tick)
    begin
      if (ms_cnt_r >= ph_len - 12'd1)
      begin
        ms_cnt_r <= '0;
        phase_r <= (single_blink && phase_r == 2'd0) ? 2'd3 : phase_r + 2'd1;
      end
      else
        ms_cnt_r <= ms_cnt_r + 12'd1;
    end
  end

  always_comb
  begin
    case (net_state_r)
      NET_NONE: net_out = 1'b0;
      NET_CALL: net_out = 1'b1;
      NET_HOME_2G, NET_HOME_3G, NET_ROAM_2G, NET_ROAM_3G: net_out = !phase_r[0];
      default: net_out = 1'b0;
    endcase
  end

  assign audio2_rx = (mode_r[5] == MODE_AUDIO2) ? sync2_r[5] : 1'b0;
  assign audio2_bitclk_in = (mode_r[7] == MODE_AUDIO2) ? sync2_r[7] : 1'b0;
  assign audio2_word_align_in = (mode_r[8] == MODE_AUDIO2) ? sync2_r[8] : 1'b0;

  // per-pin drive; pin_oe_n low means driving
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      pin_out[i] = 1'b0;
      pin_oe_n[i] = 1'b0;
      pin_pulldown[i] = 1'b0;
      case (mode_r[i])
        MODE_OUTPUT: pin_out[i] = gp_out_r[i];
        MODE_TX_BURST: pin_out[i] = burst_out_r;
        MODE_POS_SUPPLY: pin_out[i] = pos_ctrl_r;
        MODE_NETSTAT: pin_out[i] = net_out;
        MODE_TIME_SYNC: pin_out[i] = pos_ctrl_r && (pos_io_r == POS_IO_SYNC)
          && time_sync_in;
        MODE_POWER_IND: pin_out[i] = module_on;
        MODE_OPMODE_IND: pin_out[i] = module_active;
        MODE_DATA_READY:
        begin
          pin_oe_n[i] = 1'b1;
          pin_pulldown[i] = !(pos_ctrl_r && pos_io_r == POS_IO_WAKE);
        end
        MODE_CARD_DET:
        begin
          pin_oe_n[i] = 1'b1;
          pin_pulldown[i] = 1'b1;
        end
        MODE_AUDIO2:
        begin
          pin_out[i] = (i == 6) ? audio2_tx : (i == 7) ? audio2_bitclk_out
            : audio2_word_align_out;
          pin_oe_n[i] = (i == 5) || ((i >= 7) && !audio2_master);
        end
        MODE_INPUT, MODE_SERIAL: pin_oe_n[i] = 1'b1;
        default:
        begin
          pin_oe_n[i] = 1'b1;
          pin_pulldown[i] = 1'b1;
        end
      endcase
    end
  end
endmodule

// >>> hw/gfm_pkg.sv
// package for the general pin function multiplexer: mode codes, register map, timings
// assumes a 100 MHz ref_clk and a 32-bit avalon-mm register bus
package gfm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int NUM_PINS = 14;
  typedef logic [7:0] gfm_mode_type;
  localparam gfm_mode_type MODE_OUTPUT = 8'h00;
  localparam gfm_mode_type MODE_INPUT = 8'h01;
  localparam gfm_mode_type MODE_NETSTAT = 8'h02;
  localparam gfm_mode_type MODE_POS_SUPPLY = 8'h03;
  localparam gfm_mode_type MODE_DATA_READY = 8'h04;
  localparam gfm_mode_type MODE_TIME_SYNC = 8'h05;
  localparam gfm_mode_type MODE_CARD_DET = 8'h07;
  localparam gfm_mode_type MODE_TX_BURST = 8'h09;
  localparam gfm_mode_type MODE_POWER_IND = 8'h0a;
  localparam gfm_mode_type MODE_OPMODE_IND = 8'h0b;
  localparam gfm_mode_type MODE_AUDIO2 = 8'h0c;
  localparam gfm_mode_type MODE_SERIAL = 8'h0d;
  localparam gfm_mode_type MODE_PAD_OFF = 8'hff;
  // byte offsets; pin n (0-based) mode register at MODE_BASE + 4*n
  localparam logic [7:0] MODE_BASE = 8'h00;
  localparam logic [7:0] OFS_POS_CTRL = 8'h40;
  localparam logic [7:0] OFS_POS_IO = 8'h44;
  localparam logic [7:0] OFS_NET_STATE = 8'h48;
  localparam logic [7:0] OFS_GP_OUT = 8'h4c;
  localparam logic [7:0] OFS_STATUS = 8'h50;
  localparam logic [7:0] OFS_GP_IN = 8'h54;
  localparam logic [7:0] OFS_ERROR = 8'h58;
  localparam logic [7:0] POS_IO_WAKE = 8'h10;
  localparam logic [7:0] POS_IO_SYNC = 8'h20;
  // network state codes
  localparam logic [2:0] NET_NONE = 3'h0;
  localparam logic [2:0] NET_HOME_2G = 3'h1;
  localparam logic [2:0] NET_HOME_3G = 3'h2;
  localparam logic [2:0] NET_ROAM_2G = 3'h3;
  localparam logic [2:0] NET_ROAM_3G = 3'h4;
  localparam logic [2:0] NET_CALL = 3'h5;
  // status register bit positions
  localparam int ST_CARD_PRESENT = 0;
  localparam int ST_CARD_EVENT = 1;
  localparam int ST_WAKE = 2;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // timings
  localparam int BURST_LEAD_NS = 10_000;
  localparam int BURST_TAIL_NS = 5_000;
  localparam int BURST_LEAD_CYC = (BURST_LEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BURST_TAIL_CYC = (BURST_TAIL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
  localparam int T50_MS = 50;
  localparam int T100_MS = 100;
  localparam int T2S_MS = 2000;
endpackage

// >>> sim/gfm_far_side.sv
// far side of the pins: card holder, positioning receiver, processor lines
// assumes pin index 0 is pin one; an undriven line follows its pull-down
module gfm_far_side
  import gfm_pkg::*;
(
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] pin_pulldown,
  input wire logic card_in,
  input wire logic drdy_in,
  input wire logic [NUM_PINS-1:0] ext_in,
  input wire logic [NUM_PINS-1:0] ext_en,
  output logic [NUM_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_PINS-1:0] lvl;
  logic [NUM_PINS-1:0] en;
  always_comb
  begin
    lvl = ext_in;
    en = ext_en;
    lvl[4] = card_in; // holder resistors: high with card, low without
    en[4] = 1'b1;
    lvl[2] = drdy_in;
    en[2] = 1'b1;
    for (int i = 0; i < NUM_PINS; i++)
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : en[i] ? lvl[i] : !pin_pulldown[i] & !pin_out[i];
  end
endmodule

// >>> sim/gfm_mux_asserts.sv
// checker for gfm_mux: bus handshake, card detect, pin drive
// sees only gfm_mux ports; bound at the foot of this file
module gfm_mux_chk
  import gfm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] pin_pulldown,
  input wire logic audio2_rx,
  input wire logic wake_request,
  input wire logic card_present,
  input wire logic card_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic req;
  logic cd_in;
  assign req = avs_read | avs_write;
  // pull-down plus no drive happens on pin five in card mode and in pad-off mode here
  assign cd_in = pin_oe_n[4] & pin_pulldown[4];
  wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no stall on new request");
  wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("stall too long");
  read_hold_a: assert property (!avs_read ##1 !avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  no_pd_drive_a: assert property ((pin_pulldown & ~pin_oe_n) == '0)
    else $error("pull-down on driven pin");
  wake_in_a: assert property (wake_request |-> pin_oe_n[2])
    else $error("wake pin not input");
  card_evt_a: assert property (cd_in && $changed(pin_in[4]) |-> ##[1:4] card_event)
    else $error("card change missed");
  card_lvl_a: assert property ((cd_in && $stable(pin_in[4])) [*4] |-> card_present == pin_in[4])
    else $error("card level wrong");
  audio_off_a: assert property (!pin_oe_n[5] [*2] |-> !audio2_rx)
    else $error("audio rx not gated");
  cv_card_c: cover property ($rose(card_event));
  cv_wake_c: cover property ($rose(wake_request));
  cv_read_c: cover property (avs_read && !avs_waitrequest);
endmodule
bind gfm_mux gfm_mux_chk chk_u (.ref_clk(ref_clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pin_in(pin_in), .pin_oe_n(pin_oe_n), .pin_pulldown(pin_pulldown), .audio2_rx(audio2_rx),
  .wake_request(wake_request), .card_present(card_present), .card_event(card_event));

// >>> sim/gpio_function_indicator_mux_tb.sv
// self-checking bench for gfm_mux with a pin-side far model
// assumes gfm_pkg, gfm_mux, gfm_far_side and the checker compiled first
module gpio_function_indicator_mux_tb
  import gfm_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n, pin_pulldown, ext_in, ext_en;
  logic burst, mon, mact, tsync, atx, abclk, awa, amst;
  logic arx, abin, awin, wake, cpres, cevt, card_in, drdy_in;
  logic [7:0] md [1:14];
  logic [7:0] ct [14];
  int err_total, checks_done;
  gfm_mux dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pulldown(pin_pulldown),
    .tx_burst_window(burst), .module_on(mon), .module_active(mact), .time_sync_in(tsync),
    .audio2_tx(atx), .audio2_bitclk_out(abclk), .audio2_word_align_out(awa),
    .audio2_master(amst), .audio2_rx(arx), .audio2_bitclk_in(abin),
    .audio2_word_align_in(awin), .wake_request(wake), .card_present(cpres), .card_event(cevt)
  );
  gfm_far_side far_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pulldown(pin_pulldown),
    .card_in(card_in), .drdy_in(drdy_in), .ext_in(ext_in), .ext_en(ext_en), .pin_in(pin_in));
  function automatic logic [7:0] dflt(input int p);
    case (p)
      1: return MODE_PAD_OFF;
      2: return MODE_POS_SUPPLY;
      3: return MODE_DATA_READY;
      4: return MODE_TIME_SYNC;
      5: return MODE_CARD_DET;
      6, 7, 8, 9: return MODE_AUDIO2;
      default: return MODE_SERIAL;
    endcase
  endfunction
  function automatic bit acc(input int p, input logic [7:0] c);
    bit ok;
    case (c)
      MODE_OUTPUT, MODE_INPUT, MODE_PAD_OFF: ok = 1;
      MODE_NETSTAT, MODE_POS_SUPPLY: ok = p <= 5;
      MODE_DATA_READY: ok = p == 3;
      MODE_TIME_SYNC: ok = p == 4;
      MODE_CARD_DET: ok = p == 5;
      MODE_TX_BURST: ok = p == 1;
      MODE_POWER_IND: ok = p == 1 || p == 13;
      MODE_OPMODE_IND: ok = p == 14 || p == 5;
      MODE_AUDIO2: ok = p >= 6 && p <= 9;
      MODE_SERIAL: ok = p >= 10;
      default: ok = 0;
    endcase
    // single-pin functions refuse a second holder
    if (c inside {MODE_NETSTAT, MODE_POS_SUPPLY, MODE_TX_BURST, MODE_POWER_IND, MODE_OPMODE_IND})
      for (int k = 1; k <= NUM_PINS; k++)
        if (k != p && md[k] === c)
          ok = 0;
    return ok;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    rdat = avs_readdata;
    if (n >= 40)
      err_total++;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic setm(input int p, input logic [7:0] c);
    bus(1, 8'(4 * (p - 1)), {24'h0, c});
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
  initial
  begin
    int p;
    logic [7:0] c;
    bit a;
    logic [NUM_PINS-1:0] g;
    {resetn, avs_read, avs_write, burst, mon, mact, tsync, card_in, drdy_in} = '0;
    {atx, abclk, awa, amst} = '0;
    avs_address = '0;
    avs_writedata = '0;
    ext_in = '0;
    ext_en = '1;
    err_total = 0;
    checks_done = 0;
    ct = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b,
      8'h0c, 8'h0d, 8'hff};
    p = $urandom(63046);
    repeat (4) @(posedge ref_clk);
    resetn <= 1;
    for (p = 1; p <= NUM_PINS; p++)
    begin
      md[p] = dflt(p);
      setm(p, 8'h06);
      bus(0, 8'(4 * (p - 1)), 0);
      chk(rdat, {24'h0, md[p]});
    end
    $display("reset modes done");
    // pin five stays in card mode so the card checks keep their meaning
    for (int i = 0; i < 60; i++)
    begin
      p = $urandom_range(1, 13);
      if (p >= 5)
        p++;
      c = ct[$urandom_range(0, 13)];
      a = acc(p, c);
      ext_in <= NUM_PINS'($urandom);
      ext_en <= NUM_PINS'($urandom);
      {abclk, awa, amst} <= 3'($urandom);
      setm(p, c);
      if (a)
        md[p] = c;
      bus(0, OFS_ERROR, 0);
      chk(rdat[4], !a);
      bus(0, 8'(4 * (p - 1)), 0);
      chk(rdat, {24'h0, md[p]});
    end
    ext_en <= '1;
    for (p = 1; p <= NUM_PINS; p++)
      if (p != 5)
        setm(p, MODE_OUTPUT);
    g = NUM_PINS'($urandom);
    bus(1, OFS_GP_OUT, {18'h0, g});
    w(3);
    chk(pin_out & 14'h3fef, g & 14'h3fef);
    bus(0, OFS_GP_IN, 0);
    chk(rdat, {18'h0, g & 14'h3fef});
    $display("mode refusal done");
    setm(2, MODE_POS_SUPPLY);
    for (int v = 0; v < 2; v++)
    begin
      bus(1, OFS_POS_CTRL, v);
      w(2);
      chk({pin_oe_n[1], pin_out[1]}, {1'b0, 1'(v)});
    end
    setm(3, MODE_POS_SUPPLY);
    bus(0, 8'h08, 0);
    chk(rdat, MODE_OUTPUT);
    setm(3, MODE_DATA_READY);
    setm(4, MODE_TIME_SYNC);
    bus(1, OFS_POS_IO, POS_IO_WAKE);
    drdy_in <= 1;
    w(4);
    chk({wake, pin_oe_n[2], pin_oe_n[3], pin_out[3]}, 4'b1100);
    bus(1, OFS_POS_IO, POS_IO_SYNC);
    repeat (4)
    begin
      @(posedge ref_clk);
      tsync <= 1'($urandom);
      w(3);
      chk({wake, pin_oe_n[2], pin_pulldown[2], pin_out[3]}, {3'b011, tsync});
    end
    $display("positioning pins done");
    chk({pin_oe_n[4], pin_pulldown[4]}, 2'b11);
    @(posedge ref_clk);
    card_in <= 1;
    w(6);
    chk({cpres, cevt}, 2'b11);
    bus(1, OFS_STATUS, 32'h2);
    bus(0, OFS_STATUS, 0);
    chk(rdat[1:0], 2'b01);
    @(posedge ref_clk);
    card_in <= 0;
    w(6);
    chk({cpres, cevt}, 2'b01);
    $display("card detect done");
    setm(1, MODE_NETSTAT);
    for (int s = 0; s < 6; s++)
    begin
      bus(1, OFS_NET_STATE, s);
      w(3);
      chk({pin_oe_n[0], pin_out[0]}, {1'b0, s != 0});
    end
    setm(2, MODE_NETSTAT);
    bus(0, 8'h04, 0);
    chk(rdat, MODE_POS_SUPPLY);
    $display("network status done");
    setm(1, MODE_TX_BURST);
    w(1);
    chk(pin_out[0], 0);
    @(posedge ref_clk);
    burst <= 1;
    w(3);
    chk(pin_out[0], 1);
    @(posedge ref_clk);
    burst <= 0;
    w(BURST_TAIL_CYC - 10);
    chk(pin_out[0], 1);
    w(20);
    chk(pin_out[0], 0);
    $display("burst done");
    setm(13, MODE_POWER_IND);
    setm(14, MODE_OPMODE_IND);
    repeat (4)
    begin
      @(posedge ref_clk);
      {mon, mact} <= 2'($urandom);
      w(3);
      chk({pin_out[12], pin_out[13]}, {mon, mact});
    end
    setm(1, MODE_POWER_IND);
    bus(0, MODE_BASE, 0);
    chk(rdat, MODE_TX_BURST);
    for (p = 6; p <= 9; p++)
      setm(p, MODE_AUDIO2);
    repeat (4)
    begin
      @(posedge ref_clk);
      atx <= 1'($urandom);
      {abclk, awa, amst} <= 3'($urandom);
      ext_in <= NUM_PINS'($urandom);
      w(4);
      chk({pin_oe_n[6], pin_out[6], arx}, {1'b0, atx, ext_in[5]});
      chk({pin_oe_n[7], abin, awin},
        {!amst, amst ? {abclk, awa} : {ext_in[7], ext_in[8]}});
    end
    bus(0, 8'h80, 0);
    chk(rdat, RD_UNMAPPED);
    $display("indicators and audio done");
    final_report();
  end
endmodule
